// [flpe_consts.svh]
// Purpose: Constants for the serial flash program and erase sequencer.
// Assumes: Included by bare name; definitions only.
// Notes: Opcodes, counts and reset values live here; types live in the package.
`ifndef FLPE_CONSTS_SVH
`define FLPE_CONSTS_SVH

// ----------------------------------------------------------------------
// Command opcodes
// ----------------------------------------------------------------------
`define FLPE_OP_WRITE_ENABLE_CMD_CMD 8'h06
`define FLPE_OP_PP 8'h02
`define FLPE_OP_PP_W 8'h12
`define FLPE_OP_PPQ 8'h32
`define FLPE_OP_PPQ_W 8'h34
`define FLPE_OP_QUAD_ADDR_DATA_PAGE_WRITE_CMD 8'h38
`define FLPE_OP_QUAD_ADDR_DATA_PAGE_WRITE_CMD_W 8'h3E
`define FLPE_OP_SE_A 8'hD7
`define FLPE_OP_SE_B 8'h20
`define FLPE_OP_SE_W 8'h21
`define FLPE_OP_BE32 8'h52
`define FLPE_OP_BE32_W 8'h5C
`define FLPE_OP_BEBIG 8'hD8
`define FLPE_OP_BEBIG_W 8'hDC

// ----------------------------------------------------------------------
// Geometry, counts and reset values
// ----------------------------------------------------------------------
`define FLPE_SECTOR_SHIFT 12
`define FLPE_BLK32_SHIFT 15
`define FLPE_BP_BLOCK_SHIFT 16
`define FLPE_ADDR_BYTES_NARROW 3'h3
`define FLPE_ADDR_BYTES_WIDE 3'h4
`define FLPE_BITS_PER_BYTE 4'h8
`define FLPE_SYNC_RST 1'b1
`define FLPE_PROG_WAIT_CYC 5000
`define FLPE_SECT_WAIT_CYC 10000
`define FLPE_BLK_WAIT_CYC 20000

`endif

// [flpe_pkg.sv]
// Purpose: Types shared by the flash program and erase sequencer.
// Assumes: Constants come from flpe_consts.svh.
// Notes: Enumerations only.
package flpe_pkg;

  // Link decoder phases while chip select is low.
  typedef enum {
    LNK_OPC,
    LNK_ADDR,
    LNK_DATA,
    LNK_SKIP
  } flpe_link_st_t;

  // Internal operation engine states.
  typedef enum {
    ENG_IDLE,
    ENG_SCAN,
    ENG_READ,
    ENG_LAT,
    ENG_WRITE,
    ENG_ERASE,
    ENG_WAIT
  } flpe_eng_st_t;

  // Decoded command kind.
  typedef enum logic [1:0] {
    CMD_NONE,
    CMD_WRITE_ENABLE_CMD,
    CMD_PROG,
    CMD_ERASE
  } flpe_cmd_t;

  // Erase granularity presented to the array.
  typedef enum logic [1:0] {
    ERS_SECTOR,
    ERS_BLK32,
    ERS_BLKBIG
  } flpe_ers_t;

endpackage

// [flpe_seq.sv]
// Purpose: Serial flash command decoder for page program, sector and block erase.
// Assumes: Host drives chip select, clock (mode 0) and IO lines slower than mclk_i/8.
// Notes: The array sits outside; this block reads old bytes and writes merged ones.
`timescale 1ns/1ps
`default_nettype none
`include "flpe_consts.svh"

// Operation
// - Opcode 02h uses 3 or 4 address bytes per setting; 12h always 4.
// - Opcode 32h quad data, 3 or 4 address bytes; 34h always 4.
// - Opcode 38h quad address and data, 3 or 4 bytes; 3Eh always 4.
// - Page program into a protected page is ignored.
// - Program starts at chip select rise; improper release cancels it.
// - Busy flag reads 1 during programming and 0 after.
// - Extra bytes wrap in the page; only the last page worth is kept.
// - Program may start at any offset and wraps to the page start.
// - Page bytes not sent keep their previous contents.
// - Programming only clears bits; ones come back only by erase.
// - Quad input program takes data on all four IO lines.
// - Quad IO program takes address and data on all four lines.
// - Erase sets every bit of the addressed sector or block to one.
// - Sectors are 4 KB; blocks are 32 KB or the larger block size.
// - Sector erase D7h or 20h uses 3 or 4 bytes; 21h always 4.
// - Sector erase needs the latch; latch clears when erase finishes.
// - Chip select stays low through the erase command; erase starts at its rise.
// - Busy flag reads 1 during erase and 0 after.
// - Block erase 52h 32 KB, D8h larger; 5Ch and DCh always 4 bytes.
// - Block erase needs latch and proper release; latch clears at the end.
// - Opcode 06h sets the write enable latch.
module flpe_seq #(
  parameter int ADDR_W = 26,
  parameter int PAGE_BYTES = 256,
  parameter int BLOCK_KB = 64,
  parameter int PROG_WAIT_CYC = `FLPE_PROG_WAIT_CYC,
  parameter int SECT_WAIT_CYC = `FLPE_SECT_WAIT_CYC,
  parameter int BLK_WAIT_CYC = `FLPE_BLK_WAIT_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic [3:0] io_i,
  input wire logic extended_addressing_setting_i,
  input wire logic quad_enable_bit_i,
  input wire logic [3:0] block_protect_bits_i,
  input wire logic asp_locked_i,
  input wire logic [7:0] arr_rdata_i,
  output logic busy_flag_o,
  output logic write_enable_latch_o,
  output logic [ADDR_W-1:0] tgt_addr_o,
  output logic arr_re_o,
  output logic arr_we_o,
  output logic arr_erase_o,
  output flpe_pkg::flpe_ers_t arr_erase_kind_o,
  output logic [ADDR_W-1:0] arr_addr_o,
  output logic [7:0] arr_wdata_o
);
  import flpe_pkg::*;

  localparam int IDX_W = $clog2(PAGE_BYTES);
  localparam int BIG_SHIFT = $clog2(BLOCK_KB * 1024);
  localparam int unsigned NBLK = 1 << (ADDR_W - `FLPE_BP_BLOCK_SHIFT);
  localparam int CNT_W = 32;

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [5:0] pin_raw;
  logic [5:0] s1;
  logic [5:0] s2;
  logic [5:0] s3;
  logic [5:0] filt;
  logic [5:0] filt_d;

  assign pin_raw = {cs_n_i, sck_i, io_i};

  // Each pin passes three flops and changes once the last two agree.
  genvar g;
  for (g = 0; g < 6; g++) begin : g_sync
    always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
        s1[g] <= `FLPE_SYNC_RST;
        s2[g] <= `FLPE_SYNC_RST;
        s3[g] <= `FLPE_SYNC_RST;
        filt[g] <= `FLPE_SYNC_RST;
        filt_d[g] <= `FLPE_SYNC_RST;
      end else begin
        s1[g] <= pin_raw[g];
        s2[g] <= s1[g];
        s3[g] <= s2[g];
        if (s2[g] == s3[g]) begin
          filt[g] <= s3[g];
        end
        filt_d[g] <= filt[g];
      end
    end
  end

  logic cs_low;
  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic [3:0] io_s;

  assign cs_low = ~filt[5];
  assign cs_fall = filt_d[5] & ~filt[5];
  assign cs_rise = ~filt_d[5] & filt[5];
  assign sck_rise = cs_low & ~filt_d[4] & filt[4];
  assign io_s = filt[3:0];

  // ----------------------------------------------------------------------
  // Link decoder
  // ----------------------------------------------------------------------
  flpe_link_st_t lst;
  flpe_cmd_t cmd;
  flpe_ers_t ers_kind;
  flpe_eng_st_t eng;
  logic [7:0] sreg;
  logic [3:0] bitcnt;
  logic [2:0] abytes;
  logic [2:0] aneed;
  logic qaddr;
  logic qdata;
  logic got_data;
  logic [ADDR_W-1:0] addr;
  logic [IDX_W-1:0] widx;
  logic [7:0] page_buf [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] vld;
  logic start_prog;
  logic start_ers;
  logic write_enable_cmd_pulse;
  logic done_pulse;

  logic quad_now;
  logic [7:0] next_sreg;
  logic [3:0] next_bitcnt;
  logic byte_done;
  logic [31:0] prot_cnt;
  logic [31:0] blk_idx;
  logic bp_hit;
  logic proper;

  // Shift one bit on IO0 or a nibble on IO3..IO0 per clock rise.
  always_comb begin
    quad_now = (lst == LNK_ADDR && qaddr) || (lst == LNK_DATA && qdata);
    next_sreg = quad_now ? {sreg[3:0], io_s} : {sreg[6:0], io_s[0]};
    next_bitcnt = bitcnt + (quad_now ? 4'h4 : 4'h1);
    byte_done = (next_bitcnt == `FLPE_BITS_PER_BYTE);
  end

  // Block protection covers a top share of 64 KB blocks, doubling per step.
  always_comb begin
    prot_cnt = 32'h1 << (block_protect_bits_i - 4'h1);
    blk_idx = 32'(addr >> `FLPE_BP_BLOCK_SHIFT);
    bp_hit = (block_protect_bits_i != 4'h0) &&
             (prot_cnt >= NBLK || blk_idx >= NBLK - prot_cnt);
    proper = (bitcnt == 4'h0) && (lst == LNK_DATA);
  end

  // Opcode, address and data collection while chip select is low.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      lst <= LNK_SKIP;
      cmd <= CMD_NONE;
      ers_kind <= ERS_SECTOR;
      sreg <= 8'h00;
      bitcnt <= 4'h0;
      abytes <= 3'h0;
      aneed <= `FLPE_ADDR_BYTES_NARROW;
      qaddr <= 1'b0;
      qdata <= 1'b0;
      got_data <= 1'b0;
      addr <= '0;
      widx <= '0;
      vld <= '0;
      start_prog <= 1'b0;
      start_ers <= 1'b0;
      write_enable_cmd_pulse <= 1'b0;
    end else begin
      start_prog <= 1'b0;
      start_ers <= 1'b0;
      write_enable_cmd_pulse <= 1'b0;
      if (cs_fall) begin
        lst <= LNK_OPC;
        cmd <= CMD_NONE;
        bitcnt <= 4'h0;
        abytes <= 3'h0;
        qaddr <= 1'b0;
        qdata <= 1'b0;
        got_data <= 1'b0;
      end else if (cs_rise) begin
        lst <= LNK_SKIP;
        if (cmd == CMD_WRITE_ENABLE_CMD && bitcnt == 4'h0 && eng == ENG_IDLE) begin
          write_enable_cmd_pulse <= 1'b1;
        end
        if (cmd == CMD_PROG && proper && got_data && write_enable_latch_o &&
            !bp_hit && !asp_locked_i && eng == ENG_IDLE) begin
          start_prog <= 1'b1;
        end
        if (cmd == CMD_ERASE && proper && !got_data && write_enable_latch_o &&
            !bp_hit && !asp_locked_i && eng == ENG_IDLE) begin
          start_ers <= 1'b1;
        end
      end else if (sck_rise && lst != LNK_SKIP) begin
        sreg <= next_sreg;
        bitcnt <= byte_done ? 4'h0 : next_bitcnt;
        if (byte_done) begin
          case (lst)
            LNK_OPC: begin
              lst <= LNK_ADDR;
              aneed <= extended_addressing_setting_i ? `FLPE_ADDR_BYTES_WIDE :
                       `FLPE_ADDR_BYTES_NARROW;
              cmd <= CMD_PROG;
              vld <= '0;
              case (next_sreg)
                `FLPE_OP_WRITE_ENABLE_CMD_CMD: begin
                  cmd <= CMD_WRITE_ENABLE_CMD;
                  lst <= LNK_SKIP;
                end
                `FLPE_OP_PP: begin
                end
                `FLPE_OP_PP_W: begin
                  aneed <= `FLPE_ADDR_BYTES_WIDE;
                end
                `FLPE_OP_PPQ, `FLPE_OP_PPQ_W: begin
                  qdata <= 1'b1;
                  if (next_sreg == `FLPE_OP_PPQ_W) begin
                    aneed <= `FLPE_ADDR_BYTES_WIDE;
                  end
                end
                `FLPE_OP_QUAD_ADDR_DATA_PAGE_WRITE_CMD, `FLPE_OP_QUAD_ADDR_DATA_PAGE_WRITE_CMD_W: begin
                  qdata <= 1'b1;
                  qaddr <= 1'b1;
                  if (next_sreg == `FLPE_OP_QUAD_ADDR_DATA_PAGE_WRITE_CMD_W) begin
                    aneed <= `FLPE_ADDR_BYTES_WIDE;
                  end
                end
                `FLPE_OP_SE_A, `FLPE_OP_SE_B, `FLPE_OP_SE_W: begin
                  cmd <= CMD_ERASE;
                  ers_kind <= ERS_SECTOR;
                  if (next_sreg == `FLPE_OP_SE_W) begin
                    aneed <= `FLPE_ADDR_BYTES_WIDE;
                  end
                end
                `FLPE_OP_BE32, `FLPE_OP_BE32_W: begin
                  cmd <= CMD_ERASE;
                  ers_kind <= ERS_BLK32;
                  if (next_sreg == `FLPE_OP_BE32_W) begin
                    aneed <= `FLPE_ADDR_BYTES_WIDE;
                  end
                end
                `FLPE_OP_BEBIG, `FLPE_OP_BEBIG_W: begin
                  cmd <= CMD_ERASE;
                  ers_kind <= ERS_BLKBIG;
                  if (next_sreg == `FLPE_OP_BEBIG_W) begin
                    aneed <= `FLPE_ADDR_BYTES_WIDE;
                  end
                end
                default: begin
                  cmd <= CMD_NONE;
                  lst <= LNK_SKIP;
                end
              endcase
              if (eng != ENG_IDLE || (!quad_enable_bit_i &&
                  (next_sreg == `FLPE_OP_PPQ || next_sreg == `FLPE_OP_PPQ_W ||
                   next_sreg == `FLPE_OP_QUAD_ADDR_DATA_PAGE_WRITE_CMD || next_sreg == `FLPE_OP_QUAD_ADDR_DATA_PAGE_WRITE_CMD_W))) begin
                cmd <= CMD_NONE;
                lst <= LNK_SKIP;
              end
            end
            LNK_ADDR: begin
              addr <= ADDR_W'({32'(addr), next_sreg});
              abytes <= abytes + 3'h1;
              if (abytes + 3'h1 == aneed) begin
                lst <= LNK_DATA;
                widx <= next_sreg[IDX_W-1:0];
                if (aneed == `FLPE_ADDR_BYTES_NARROW) begin
                  addr <= ADDR_W'({addr[15:0], next_sreg});
                end
              end
            end
            default: begin
              got_data <= 1'b1;
              if (cmd == CMD_PROG) begin
                vld[widx] <= 1'b1;
                widx <= widx + 1'b1;
              end
            end
          endcase
        end
      end
    end
  end

  // Page buffer storage; no reset needed since valid bits guard it.
  always_ff @(posedge mclk_i) begin
    if (sck_rise && !cs_fall && !cs_rise && lst == LNK_DATA && byte_done &&
        cmd == CMD_PROG) begin
      page_buf[widx] <= next_sreg;
    end
  end

  // ----------------------------------------------------------------------
  // Internal operation engine
  // ----------------------------------------------------------------------
  logic [IDX_W-1:0] ridx;
  logic [CNT_W-1:0] wait_cnt;
  logic [ADDR_W-1:0] ers_mask;

  always_comb begin
    case (ers_kind)
      ERS_SECTOR: ers_mask = ADDR_W'((64'h1 << `FLPE_SECTOR_SHIFT) - 64'h1);
      ERS_BLK32: ers_mask = ADDR_W'((64'h1 << `FLPE_BLK32_SHIFT) - 64'h1);
      default: ers_mask = ADDR_W'((64'h1 << BIG_SHIFT) - 64'h1);
    endcase
  end

  // Walks the page merging old and new bytes, or issues one erase.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      eng <= ENG_IDLE;
      ridx <= '0;
      wait_cnt <= '0;
      done_pulse <= 1'b0;
      busy_flag_o <= 1'b0;
      arr_re_o <= 1'b0;
      arr_we_o <= 1'b0;
      arr_erase_o <= 1'b0;
      arr_erase_kind_o <= ERS_SECTOR;
      arr_addr_o <= '0;
      arr_wdata_o <= 8'h00;
    end else begin
      done_pulse <= 1'b0;
      arr_re_o <= 1'b0;
      arr_we_o <= 1'b0;
      arr_erase_o <= 1'b0;
      case (eng)
        ENG_IDLE: begin
          ridx <= '0;
          if (start_prog) begin
            eng <= ENG_SCAN;
            busy_flag_o <= 1'b1;
          end else if (start_ers) begin
            eng <= ENG_ERASE;
            busy_flag_o <= 1'b1;
          end
        end
        ENG_SCAN: begin
          if (vld[ridx]) begin
            eng <= ENG_READ;
            arr_re_o <= 1'b1;
            arr_addr_o <= {addr[ADDR_W-1:IDX_W], ridx};
          end else if (ridx == IDX_W'(PAGE_BYTES - 1)) begin
            eng <= ENG_WAIT;
            wait_cnt <= CNT_W'(PROG_WAIT_CYC);
          end else begin
            ridx <= ridx + 1'b1;
          end
        end
        ENG_READ: begin
          eng <= ENG_LAT;
        end
        ENG_LAT: begin
          eng <= ENG_WRITE;
          arr_we_o <= 1'b1;
          arr_wdata_o <= arr_rdata_i & page_buf[ridx];
        end
        ENG_WRITE: begin
          if (ridx == IDX_W'(PAGE_BYTES - 1)) begin
            eng <= ENG_WAIT;
            wait_cnt <= CNT_W'(PROG_WAIT_CYC);
          end else begin
            eng <= ENG_SCAN;
            ridx <= ridx + 1'b1;
          end
        end
        ENG_ERASE: begin
          arr_erase_o <= 1'b1;
          arr_erase_kind_o <= ers_kind;
          arr_addr_o <= addr & ~ers_mask;
          eng <= ENG_WAIT;
          wait_cnt <= (ers_kind == ERS_SECTOR) ? CNT_W'(SECT_WAIT_CYC) :
                      CNT_W'(BLK_WAIT_CYC);
        end
        default: begin
          if (wait_cnt <= CNT_W'(1)) begin
            eng <= ENG_IDLE;
            busy_flag_o <= 1'b0;
            done_pulse <= 1'b1;
          end else begin
            wait_cnt <= wait_cnt - CNT_W'(1);
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Write enable latch and target address
  // ----------------------------------------------------------------------
  // Latch clears at completion
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      write_enable_latch_o <= 1'b0;
    end else if (write_enable_cmd_pulse) begin
      write_enable_latch_o <= 1'b1;
    end else if (done_pulse) begin
      write_enable_latch_o <= 1'b0;
    end
  end

  // Address presented to the sector protection lookup.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      tgt_addr_o <= '0;
    end else begin
      tgt_addr_o <= addr;
    end
  end

endmodule
`default_nettype wire

// [flpe_seq_asserts.sv]
// Purpose: Port-level checks for the flash program and erase sequencer.
// Assumes: Bound into every flpe_seq instance; one clock domain.
// Notes: Array strobes are one-cycle pulses from registers.
`timescale 1ns/1ps
`default_nettype none
module flpe_seq_asserts #(
  parameter int ADDR_W = 26
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic [3:0] io_i,
  input wire logic extended_addressing_setting_i,
  input wire logic quad_enable_bit_i,
  input wire logic [3:0] block_protect_bits_i,
  input wire logic asp_locked_i,
  input wire logic [7:0] arr_rdata_i,
  input wire logic busy_flag_o,
  input wire logic write_enable_latch_o,
  input wire logic [ADDR_W-1:0] tgt_addr_o,
  input wire logic arr_re_o,
  input wire logic arr_we_o,
  input wire logic arr_erase_o,
  input wire flpe_pkg::flpe_ers_t arr_erase_kind_o,
  input wire logic [ADDR_W-1:0] arr_addr_o,
  input wire logic [7:0] arr_wdata_o
);
  import flpe_pkg::*;

  // Every check runs on the system clock and rests during reset.
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  a_strobe_busy: assert property ((arr_re_o || arr_we_o || arr_erase_o) |-> busy_flag_o)
    else $error("array strobe while idle");
  a_we_order: assert property (arr_we_o |-> $past(arr_re_o, 2))
    else $error("write not preceded by read");
  a_merge_only: assert property (arr_we_o |-> (arr_wdata_o & ~$past(arr_rdata_i)) == 8'h00)
    else $error("write data sets a cleared bit");
  a_sector_align: assert property (arr_erase_o && arr_erase_kind_o == ERS_SECTOR
    |-> arr_addr_o[11:0] == 12'h000)
    else $error("sector erase base not aligned");
  a_blk32_align: assert property (arr_erase_o && arr_erase_kind_o == ERS_BLK32
    |-> arr_addr_o[14:0] == 15'h0000)
    else $error("block erase base not aligned");
  a_start_release: assert property ($rose(busy_flag_o) |-> cs_n_i && $past(cs_n_i, 3))
    else $error("operation started without release");
  a_start_latch: assert property ($rose(busy_flag_o) |-> $past(write_enable_latch_o))
    else $error("operation started with latch clear");
  a_latch_clear: assert property ($fell(busy_flag_o) |-> ##[0:1] !write_enable_latch_o)
    else $error("latch not cleared at completion");
  a_latch_idle: assert property ($rose(write_enable_latch_o) |-> !busy_flag_o)
    else $error("latch set while busy");
endmodule

bind flpe_seq flpe_seq_asserts #(.ADDR_W(ADDR_W)) chk (.*);
`default_nettype wire

// [flpe_host_model.sv]
// Purpose: Behavioural host controller driving the flash link pins.
// Assumes: Mode 0 clock, eight system clocks per serial clock.
// Notes: Pins change only at falling system clock edges.
`timescale 1ns/1ps
`default_nettype none
module flpe_host_model (
  input wire logic mclk_i,
  output logic cs_n_o,
  output logic sck_o,
  output logic [3:0] io_o
);
  // Idle link: deselected, serial clock parked low.
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    io_o = 4'h5;
  end

  // Select held low through the command.
  task automatic start();
    @(negedge mclk_i);
    cs_n_o = 1'b0;
    repeat (4) @(negedge mclk_i);
  endtask

  // Shifts units of b MSB first; a unit is one bit on IO0 or one nibble.
  task automatic put(input logic [7:0] b, input bit quad, input int units);
    for (int k = 0; k < units; k++) begin
      io_o = quad ? b[7-4*k -: 4] : {~io_o[3:1], b[7-k]};
      repeat (4) @(negedge mclk_i);
      sck_o = 1'b1;
      repeat (4) @(negedge mclk_i);
      sck_o = 1'b0;
    end
  endtask

  // Releases select; the released lines show the inverse of their last value.
  task automatic stop();
    repeat (2) @(negedge mclk_i);
    cs_n_o = 1'b1;
    io_o = ~io_o;
    repeat (8) @(negedge mclk_i);
  endtask
endmodule
`default_nettype wire

// [flpe_tb.sv]
// Purpose: Self-checking bench for the flash program and erase sequencer.
// Assumes: Short wait parameters; behavioural array without erase.
// Notes: Write and erase strobes are compared in order against queued notes; read strobes are not.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import flpe_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic ext = 1'b0;
  logic qe = 1'b0;
  logic advanced_sector_protection = 1'b0;
  logic [3:0] bp = 4'h0;
  logic [7:0] rdata = 8'hFF;
  logic cs_n, sck, busy, write_enable_latch, re, we, ers;
  logic [3:0] io;
  logic [25:0] addr;
  logic [25:0] tgt;
  logic [7:0] wdata;
  flpe_ers_t kind;
  logic [7:0] mem [int];
  logic [7:0] shd [int];
  logic [36:0] expq [$];
  logic [31:0] seed = 32'h4B8E;
  logic [31:0] r;
  logic [7:0] pops [6] = '{8'h02, 8'h12, 8'h32, 8'h34, 8'h38, 8'h3E};
  logic [7:0] eops [7] = '{8'hD7, 8'h20, 8'h21, 8'h52, 8'h5C, 8'hD8, 8'hDC};
  int err_count = 0;
  int compares = 0;
  int cyc = 0;

  always #20 mclk = ~mclk;

  flpe_seq #(.PROG_WAIT_CYC(20), .SECT_WAIT_CYC(400), .BLK_WAIT_CYC(20)) uut (
    .mclk_i(mclk), .rst_i(rst), .cs_n_i(cs_n), .sck_i(sck), .io_i(io),
    .extended_addressing_setting_i(ext), .quad_enable_bit_i(qe),
    .block_protect_bits_i(bp), .asp_locked_i(advanced_sector_protection), .arr_rdata_i(rdata),
    .busy_flag_o(busy), .write_enable_latch_o(write_enable_latch), .tgt_addr_o(tgt),
    .arr_re_o(re), .arr_we_o(we), .arr_erase_o(ers), .arr_erase_kind_o(kind),
    .arr_addr_o(addr), .arr_wdata_o(wdata));

  flpe_host_model host (.mclk_i(mclk), .cs_n_o(cs_n), .sck_o(sck), .io_o(io));

  // Array: read data valid one cycle, then scrambled so stale use shows.
  always @(posedge mclk) begin
    if (re) rdata <= mem.exists(addr) ? mem[addr] : 8'hFF;
    else rdata <= ~rdata;
    if (we) mem[addr] = wdata;
  end

  // Each write or erase strobe takes the oldest note off the queue.
  always @(posedge mclk) begin
    if (we || ers) begin
      if (expq.size() == 0) cmp(37'h0, 37'h1, "unexpected array strobe");
      else cmp({ers, ers ? kind : ERS_SECTOR, addr, we ? wdata : 8'h00},
        expq.pop_front(), "array strobe");
    end
  end

  // A hang counts as a mismatch and ends the run.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 80000) begin
      err_count++;
      give_verdict();
    end
  end

  task automatic cmp(input logic [36:0] got, input logic [36:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic cmp_flag(input logic [1:0] got, input logic [1:0] exp, input string msg);
    cmp({35'h0, got}, {35'h0, exp}, msg);
  endtask

  task automatic give_verdict();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  function automatic logic [31:0] xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic write_enable_cmd();
    host.start();
    host.put(8'h06, 1'b0, 8);
    host.stop();
    cmp_flag({1'b0, write_enable_latch}, 2'b01, "latch after enable");
  endtask

  // Opcode on IO0, then three or four address bytes.
  task automatic frame(input logic [7:0] op, input logic [31:0] a, input bit qa);
    bit w;
    w = ext || op inside {8'h12, 8'h34, 8'h3E, 8'h21, 8'h5C, 8'hDC};
    host.start();
    host.put(op, 1'b0, 8);
    for (int i = w ? 3 : 2; i >= 0; i--) host.put(a[8*i +: 8], qa, qa ? 2 : 8);
  endtask

  // Waits out the operation; busy must follow ok, latch must end as wl.
  task automatic finish_op(input bit ok, input bit wl);
    int t;
    t = 0;
    while (busy !== 1'b1 && t < 12) begin
      @(negedge mclk);
      t++;
    end
    cmp_flag({1'b0, busy}, {1'b0, ok}, "busy after release");
    t = 0;
    while (busy !== 1'b0 && t < 3000) begin
      @(negedge mclk);
      t++;
    end
    repeat (2) @(negedge mclk);
    cmp_flag({busy, write_enable_latch}, {1'b0, wl}, "flags after operation");
  endtask

  task automatic prog(input logic [7:0] op, input logic [31:0] a, input int n, input bit en,
    input bit ok);
    logic [7:0] pg [int];
    logic [7:0] d;
    logic [25:0] p;
    bit qa, qd;
    qa = op inside {8'h38, 8'h3E};
    qd = qa || op inside {8'h32, 8'h34};
    if (en) write_enable_cmd();
    frame(op, a, qa);
    for (int k = 0; k < n; k++) begin
      r = xorshift();
      host.put(r[7:0], qd, qd ? 2 : 8);
      pg[(a[7:0] + k) % 256] = r[7:0];
    end
    if (ok) begin
      foreach (pg[o]) begin
        p = {a[25:8], o[7:0]};
        d = (shd.exists(p) ? shd[p] : 8'hFF) & pg[o];
        shd[p] = d;
        expq.push_back({1'b0, ERS_SECTOR, p, d});
      end
    end
    host.stop();
    // A narrow address arrives zero-extended on the target port.
    if (ok) cmp({11'h0, tgt}, {11'h0, (ext || op inside {8'h12, 8'h34, 8'h3E}) ? a[25:0] :
      {2'b00, a[23:0]}}, "target address");
    finish_op(ok, en && !ok);
  endtask

  task automatic erase(input logic [7:0] op, input logic [31:0] a, input bit en, input bit ok,
    input int extra);
    flpe_ers_t k;
    logic [25:0] m;
    k = op inside {8'h52, 8'h5C} ? ERS_BLK32 : op inside {8'hD8, 8'hDC} ? ERS_BLKBIG : ERS_SECTOR;
    m = k == ERS_SECTOR ? 26'h3FFF000 : k == ERS_BLK32 ? 26'h3FF8000 : 26'h3FF0000;
    if (en) write_enable_cmd();
    frame(op, a, 1'b0);
    host.put(8'hFF, 1'b0, extra);
    if (ok) expq.push_back({1'b1, k, a[25:0] & m, 8'h00});
    host.stop();
    finish_op(ok, en && !ok);
  endtask

  initial begin
    repeat (10) @(negedge mclk);
    rst = 1'b0;
    repeat (4) @(negedge mclk);
    prog(8'h02, 32'h1FE, 3, 1'b0, 1'b0);
    prog(8'h02, 32'h1FE, 3, 1'b1, 1'b1);
    prog(8'h02, 32'h100, 1, 1'b1, 1'b1);
    prog(8'h12, 32'h200, 258, 1'b1, 1'b1);
    prog(8'h32, 32'h300, 1, 1'b1, 1'b0);
    qe = 1'b1;
    foreach (pops[i]) begin
      ext = i[0];
      r = xorshift();
      prog(pops[i], {12'h000, 4'(i + 1), 8'h00, r[7:0]}, 2, 1'b1, 1'b1);
    end
    foreach (eops[i]) begin
      ext = i[0];
      r = xorshift();
      erase(eops[i], {8'h00, r[23:0]}, 1'b1, 1'b1, 0);
    end
    ext = 1'b0;
    bp = 4'h1;
    prog(8'h12, 32'h03FF0010, 1, 1'b1, 1'b0);
    bp = 4'h0;
    advanced_sector_protection = 1'b1;
    prog(8'h02, 32'h800, 1, 1'b1, 1'b0);
    advanced_sector_protection = 1'b0;
    erase(8'h20, 32'h7000, 1'b0, 1'b1, 0);
    erase(8'hD8, 32'h20000, 1'b1, 1'b0, 3);
    write_enable_cmd();
    frame(8'h20, 32'h5000, 1'b0);
    expq.push_back({1'b1, ERS_SECTOR, 26'h0005000, 8'h00});
    host.stop();
    frame(8'h20, 32'h6000, 1'b0);
    host.stop();
    finish_op(1'b1, 1'b0);
    cmp(37'(expq.size()), 37'h0, "missing array strobes");
    give_verdict();
  end
endmodule
`default_nettype wire
